// ===== hw/host_port_pkg.sv
// constants shared by the host bus strobe and strap front end
package host_port_pkg;
   // serial clock timing: 4 us period at 100 MHz
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned SK_PERIOD_NS     = 4000;
   localparam int unsigned SK_HALF_CYCLES   =
      (SK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SK_CNT_W         = 8;
   // configuration memory load: read command then data words
   localparam int unsigned CMD_BITS         = 11;
   localparam int unsigned DATA_BITS        = 16;
   localparam int unsigned CFG_WORDS        = 8;
   localparam int unsigned WORD_IDX_W       = 3;
   localparam int unsigned BIT_CNT_W        = 5;
   localparam logic [2:0]  READ_OPCODE      = 3'h6;
   // address fields
   localparam int unsigned ADDR_HI          = 15;
   localparam int unsigned ADDR_LO          = 1;
   localparam int unsigned DEC_LO           = 4;
   localparam int unsigned BASE_W           = ADDR_HI - DEC_LO + 1;
   localparam logic [BASE_W-1:0] BASE_RESET = 12'h030;
   localparam logic [DATA_BITS-1:0] WORD_RESET = 16'h0000;
   // load sequencer states, one-hot
   typedef enum logic [3:0] {
      LD_IDLE = 4'h1,
      LD_CMD  = 4'h2,
      LD_DATA = 4'h4,
      LD_DONE = 4'h8
   } load_state_t;
endpackage : host_port_pkg

// ===== hw/cfg_word_mem.sv
// small memory holding the configuration words loaded from serial memory
`timescale 1ns/1ps
module cfg_word_mem
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        wr_en_i,
   input  wire logic [2:0]  wr_idx_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic [2:0]  rd_idx_i,
   output logic      [15:0] rd_data_o
);
   logic [15:0] mem_reg [0:host_port_pkg::CFG_WORDS-1];

   // one write port per entry
   genvar g;
   generate
      for (g = 0; g < host_port_pkg::CFG_WORDS; g++)
      begin : g_word
         always_ff @(posedge clk_sys_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               mem_reg[g] <= host_port_pkg::WORD_RESET;
            else if (wr_en_i && (wr_idx_i == 3'(g)))
               mem_reg[g] <= wr_data_i;
         end
      end
   endgenerate

   // registered read
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rd_data_o <= host_port_pkg::WORD_RESET;
      else
         rd_data_o <= mem_reg[rd_idx_i];
   end
endmodule : cfg_word_mem

// ===== hw/host_bus_strobes_and_straps.sv
// host bus strobe front end with strap capture and config memory load
`timescale 1ns/1ps
module host_bus_strobes_and_straps
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // straps and serial memory
   input  wire logic        cfg_mem_present_strap_i,
   input  wire logic        cfg_mem_serial_in_i,
   output logic             cfg_mem_serial_out_o,
   output logic             cfg_mem_serial_clock_o,
   output logic             cfg_mem_select_o,
   input  wire logic        wide_bus_variant_i,
   // host bus
   input  wire logic [15:1] addr_i,
   input  wire logic        address_qualifier_n_i,
   input  wire logic        address_latch_strobe_n_i,
   input  wire logic        latch_mode_i,
   input  wire logic        sync_write_read_select_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic        read_strobe_n_i,
   input  wire logic [15:0] write_data_i,
   input  wire logic [2:0]  cfg_read_idx_i,
   input  wire logic        chip_power_down_n_i,
   // results
   output logic             local_select_n_o,
   output logic             bus_16bit_o,
   output logic             cfg_mem_present_o,
   output logic             sync_is_write_o,
   output logic             async_write_o,
   output logic [15:0]      async_write_data_o,
   output logic             async_read_o,
   output logic [15:0]      read_data_o,
   output logic [15:1]      latched_addr_o,
   output logic             load_done_o,
   output logic             power_down_o
);
   localparam int unsigned HALF = host_port_pkg::SK_HALF_CYCLES;

   host_port_pkg::load_state_t st_reg;
   logic                     straps_taken_reg;
   logic [host_port_pkg::SK_CNT_W-1:0]  sk_cnt_reg;
   logic                     sk_reg;
   logic                     sk_fall;
   logic                     sk_rise;
   logic [host_port_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
   logic [2:0]               word_idx_reg;
   logic [15:0]              shift_reg;
   logic                     mem_wr;
   logic [15:0]              mem_rd_data;
   logic                     ads_prev_reg;
   logic                     qual_lat_reg;
   logic [15:1]              addr_eff;
   logic                     qual_eff;
   logic [host_port_pkg::BASE_W-1:0] base_reg;
   logic [host_port_pkg::CMD_BITS-1:0] cmd_word;

   // ==================================================================
   // strap capture
   // ==================================================================
   // straps caught once, first edge after release
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         straps_taken_reg  <= 1'b0;
         cfg_mem_present_o <= 1'b0;
         bus_16bit_o       <= 1'b0;
      end
      else if (!straps_taken_reg)
      begin
         straps_taken_reg  <= 1'b1;
         cfg_mem_present_o <= cfg_mem_present_strap_i;
         // serial input level is the width strap when no memory is strapped present; ignored on 32-bit part
         bus_16bit_o <= !wide_bus_variant_i
                        && !cfg_mem_present_strap_i
                        && cfg_mem_serial_in_i;
      end
   end

   // ==================================================================
   // serial clock and load sequencer
   // ==================================================================
   assign sk_fall = (st_reg == host_port_pkg::LD_CMD
                     || st_reg == host_port_pkg::LD_DATA)
                    && sk_reg
                    && (sk_cnt_reg == host_port_pkg::SK_CNT_W'(HALF - 1));
   assign sk_rise = (st_reg == host_port_pkg::LD_CMD
                     || st_reg == host_port_pkg::LD_DATA)
                    && !sk_reg
                    && (sk_cnt_reg == host_port_pkg::SK_CNT_W'(HALF - 1));

   // half-period counter, toggles clock every 2 us
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sk_cnt_reg <= '0;
         sk_reg     <= 1'b0;
      end
      else if (st_reg == host_port_pkg::LD_CMD
               || st_reg == host_port_pkg::LD_DATA)
      begin
         if (sk_cnt_reg == host_port_pkg::SK_CNT_W'(HALF - 1))
         begin
            sk_cnt_reg <= '0;
            sk_reg     <= !sk_reg;
         end
         else
            sk_cnt_reg <= sk_cnt_reg + 1'b1;
      end
      else
      begin
         sk_cnt_reg <= '0;
         sk_reg     <= 1'b0;
      end
   end

   assign cmd_word = {host_port_pkg::READ_OPCODE, 5'h00, word_idx_reg};

   // command shift out on falling edge, data sampled on rising edge
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_reg       <= host_port_pkg::LD_IDLE;
         bit_cnt_reg  <= '0;
         word_idx_reg <= '0;
         shift_reg    <= host_port_pkg::WORD_RESET;
      end
      else
      begin
         case (st_reg)
            host_port_pkg::LD_IDLE:
               if (straps_taken_reg && cfg_mem_present_o)
               begin
                  st_reg      <= host_port_pkg::LD_CMD;
                  bit_cnt_reg <= '0;
               end
               else if (straps_taken_reg)
                  st_reg <= host_port_pkg::LD_DONE;
            host_port_pkg::LD_CMD:
               if (sk_fall)
               begin
                  if (bit_cnt_reg ==
                      host_port_pkg::BIT_CNT_W'(host_port_pkg::CMD_BITS - 1))
                  begin
                     st_reg      <= host_port_pkg::LD_DATA;
                     bit_cnt_reg <= '0;
                  end
                  else
                     bit_cnt_reg <= bit_cnt_reg + 1'b1;
               end
            host_port_pkg::LD_DATA:
               // count parks past the last bit until the clock falls again
               if (sk_rise)
               begin
                  shift_reg <= {shift_reg[14:0], cfg_mem_serial_in_i};
                  bit_cnt_reg <= bit_cnt_reg + 1'b1;
               end
               else if (sk_fall && bit_cnt_reg ==
                        host_port_pkg::BIT_CNT_W'(host_port_pkg::DATA_BITS))
               begin
                  bit_cnt_reg  <= '0;
                  word_idx_reg <= word_idx_reg + 1'b1;
                  if (word_idx_reg == host_port_pkg::WORD_IDX_W'(
                         host_port_pkg::CFG_WORDS - 1))
                     st_reg <= host_port_pkg::LD_DONE;
                  else
                     st_reg <= host_port_pkg::LD_CMD;
               end
            host_port_pkg::LD_DONE:
               st_reg <= host_port_pkg::LD_DONE;
            default:
               st_reg <= host_port_pkg::LD_IDLE;
         endcase
      end
   end

   assign mem_wr = (st_reg == host_port_pkg::LD_DATA) && sk_rise
      && (bit_cnt_reg ==
          host_port_pkg::BIT_CNT_W'(host_port_pkg::DATA_BITS - 1));

   // serial pin outputs
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cfg_mem_serial_out_o   <= 1'b0;
         cfg_mem_serial_clock_o <= 1'b0;
         cfg_mem_select_o       <= 1'b0;
         load_done_o            <= 1'b0;
      end
      else
      begin
         cfg_mem_serial_clock_o <= sk_reg;
         cfg_mem_select_o <= (st_reg == host_port_pkg::LD_CMD)
                             || (st_reg == host_port_pkg::LD_DATA);
         cfg_mem_serial_out_o <= (st_reg == host_port_pkg::LD_CMD)
            && cmd_word[host_port_pkg::CMD_BITS - 1
                        - 32'(bit_cnt_reg)];
         load_done_o <= (st_reg == host_port_pkg::LD_DONE);
      end
   end

   cfg_word_mem u_mem
   (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .wr_en_i   (mem_wr),
      .wr_idx_i  (word_idx_reg),
      .wr_data_i ({shift_reg[14:0], cfg_mem_serial_in_i}),
      .rd_idx_i  (cfg_read_idx_i),
      .rd_data_o (mem_rd_data)
   );

   // base address taken from top 12 bits of loaded word 0
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         base_reg <= host_port_pkg::BASE_RESET;
      else if (mem_wr && word_idx_reg == '0)
         base_reg <= {shift_reg[14:3]};
   end

   // ==================================================================
   // address latch and decode
   // ==================================================================
   // capture on latch strobe rising edge
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ads_prev_reg   <= 1'b1;
         latched_addr_o <= '0;
         qual_lat_reg   <= 1'b1;
      end
      else
      begin
         ads_prev_reg <= address_latch_strobe_n_i;
         if (!ads_prev_reg && address_latch_strobe_n_i)
         begin
            latched_addr_o <= addr_i;
            qual_lat_reg   <= address_qualifier_n_i;
         end
      end
   end

   assign addr_eff = latch_mode_i ? latched_addr_o : addr_i;
   assign qual_eff = latch_mode_i ? qual_lat_reg : address_qualifier_n_i;

   // registered decode, strobes and power-down
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         local_select_n_o   <= 1'b1;
         sync_is_write_o    <= 1'b0;
         async_write_o      <= 1'b0;
         async_write_data_o <= '0;
         async_read_o       <= 1'b0;
         read_data_o        <= '0;
         power_down_o       <= 1'b0;
      end
      else
      begin
         local_select_n_o <= !(!qual_eff
            && addr_eff[host_port_pkg::ADDR_HI:host_port_pkg::DEC_LO]
               == base_reg);
         sync_is_write_o <= sync_write_read_select_i;
         async_write_o   <= !qual_eff && !write_strobe_n_i;
         if (!qual_eff && !write_strobe_n_i)
            async_write_data_o <= write_data_i;
         async_read_o <= !qual_eff && !read_strobe_n_i;
         read_data_o  <= (!qual_eff && !read_strobe_n_i)
                         ? mem_rd_data : '0;
         power_down_o <= !chip_power_down_n_i;
      end
   end
endmodule : host_bus_strobes_and_straps

// ===== test/host_bus_strobes_and_straps_assertions.sv
// concurrent checks on the host strobe and strap front end ports
`timescale 1ns/1ps
module host_bus_strobes_and_straps_chk
(
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic [15:1] addr_i,
   input wire logic        address_qualifier_n_i,
   input wire logic        address_latch_strobe_n_i,
   input wire logic        latch_mode_i,
   input wire logic        sync_write_read_select_i,
   input wire logic        write_strobe_n_i,
   input wire logic        read_strobe_n_i,
   input wire logic [15:0] write_data_i,
   input wire logic        chip_power_down_n_i,
   input wire logic        local_select_n_o,
   input wire logic        bus_16bit_o,
   input wire logic        cfg_mem_present_o,
   input wire logic        cfg_mem_select_o,
   input wire logic        cfg_mem_serial_clock_o,
   input wire logic        sync_is_write_o,
   input wire logic        async_write_o,
   input wire logic [15:0] async_write_data_o,
   input wire logic        async_read_o,
   input wire logic [15:1] latched_addr_o,
   input wire logic        power_down_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================
   // helper counters
   logic [8:0] sk_cnt_reg;
   logic       sk_q_reg;
   logic       sk_seen_reg;
   logic [1:0] up_cnt_reg;
   wire        sk_chg = cfg_mem_serial_clock_o != sk_q_reg;
   wire        direct = !latch_mode_i && !address_qualifier_n_i;
   // cycles since last serial clock edge, any edge seen flag, cycles since reset release (saturating at 3)
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sk_cnt_reg  <= 9'h000;
         sk_q_reg    <= 1'b0;
         sk_seen_reg <= 1'b0;
         up_cnt_reg  <= 2'h0;
      end
      else
      begin
         sk_q_reg    <= cfg_mem_serial_clock_o;
         sk_cnt_reg  <= sk_chg ? 9'h000 : sk_cnt_reg + 9'h001;
         sk_seen_reg <= sk_seen_reg | sk_chg;
         up_cnt_reg  <= (up_cnt_reg == 2'h3) ? 2'h3 : up_cnt_reg + 2'h1;
      end
   end
   // ==========================================
   // properties
   property p_sk_half; sk_chg && sk_seen_reg |-> sk_cnt_reg == 9'd199; endproperty
   property p_sync_wr; sync_write_read_select_i |=> sync_is_write_o; endproperty
   property p_sync_rd; !sync_write_read_select_i |=> !sync_is_write_o; endproperty
   property p_unqual;
      !latch_mode_i && address_qualifier_n_i
         |=> local_select_n_o && !async_write_o && !async_read_o;
   endproperty
   property p_async_wr;
      direct && !write_strobe_n_i
         |=> async_write_o && async_write_data_o == $past(write_data_i);
   endproperty
   property p_async_rd; direct && !read_strobe_n_i |=> async_read_o; endproperty
   property p_latch;
      $rose(address_latch_strobe_n_i) |=> latched_addr_o == $past(addr_i);
   endproperty
   property p_pd_on; !chip_power_down_n_i |=> power_down_o; endproperty
   property p_pd_off; chip_power_down_n_i |=> !power_down_o; endproperty
   property p_absent; !cfg_mem_present_o |-> !cfg_mem_select_o; endproperty
   property p_strap_hold;
      up_cnt_reg >= 2'h2 |-> $stable(cfg_mem_present_o) && $stable(bus_16bit_o);
   endproperty
   a_sk_half: assert property (p_sk_half) else $error("serial clock half period wrong");
   a_sync_wr: assert property (p_sync_wr) else $error("write cycle not decoded");
   a_sync_rd: assert property (p_sync_rd) else $error("read cycle not decoded");
   a_unqual: assert property (p_unqual) else $error("unqualified access taken");
   a_async_wr: assert property (p_async_wr) else $error("async write missed");
   a_async_rd: assert property (p_async_rd) else $error("async read missed");
   a_latch: assert property (p_latch) else $error("address not latched");
   a_pd_on: assert property (p_pd_on) else $error("power down not entered");
   a_pd_off: assert property (p_pd_off) else $error("power down not left");
   a_absent: assert property (p_absent) else $error("load without memory");
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
   c_wr: cover property (direct && !write_strobe_n_i);
   c_sk: cover property (sk_chg && sk_seen_reg);
   c_latch: cover property ($rose(address_latch_strobe_n_i));
endmodule : host_bus_strobes_and_straps_chk
bind host_bus_strobes_and_straps host_bus_strobes_and_straps_chk u_chk
(
   .clk_sys_i, .rst_n_i, .addr_i, .address_qualifier_n_i,
   .address_latch_strobe_n_i, .latch_mode_i, .sync_write_read_select_i,
   .write_strobe_n_i, .read_strobe_n_i, .write_data_i, .chip_power_down_n_i,
   .local_select_n_o, .bus_16bit_o, .cfg_mem_present_o, .cfg_mem_select_o,
   .cfg_mem_serial_clock_o, .sync_is_write_o, .async_write_o,
   .async_write_data_o, .async_read_o, .latched_addr_o, .power_down_o
);

// ===== test/cfg_mem_model.sv
// serial configuration memory model answering read commands
`timescale 1ns/1ps
module cfg_mem_model
(
   input  wire logic        sk_i,
   input  wire logic        cs_i,
   input  wire logic        di_i,
   output logic             do_o,
   output logic [10:0]      first_cmd_o,
   output logic [3:0]       words_o
);
   logic [4:0]  n_reg;
   logic [10:0] cmd_reg;
   wire  [15:0] word = 16'h1230 + {13'h0000, cmd_reg[2:0]};
   initial words_o = 4'h0;
   // shift command in on rising clock, count bits of each word
   always @(posedge sk_i or negedge cs_i)
   begin
      if (!cs_i)
         n_reg <= 5'h00;
      else
      begin
         if (n_reg < 5'd11)
            cmd_reg <= {cmd_reg[9:0], di_i};
         if (n_reg == 5'd10 && words_o == 4'h0)
            first_cmd_o <= {cmd_reg[9:0], di_i};
         if (n_reg == 5'd26)
            words_o <= words_o + 4'h1;
         n_reg <= (n_reg == 5'd26) ? 5'h00 : n_reg + 5'h01;
      end
   end
   // data out changes on falling clock, pulled low when released
   always @(negedge sk_i or negedge cs_i)
   begin
      if (!cs_i || n_reg < 5'd11)
         do_o <= 1'b0;
      else
         do_o <= word[5'd26 - n_reg];
   end
endmodule : cfg_mem_model

// ===== test/host_bus_strobes_and_straps_tb.sv
// self-checking bench for the host strobe and strap front end
`timescale 1ns/1ps
module host_bus_strobes_and_straps_tb;
   logic clk_sys_i, rst_n_i, strap, lvl, mem_do, wide, aq_n, als_n, lmode;
   logic sync_write_read_select, wr_n, rd_n, pd_n, so, sk, sel, ls_n, b16, pres, sw, aw, ar;
   logic done, pdo;
   logic [15:1] addr, laddr;
   logic [15:0] wd, awd, rdd;
   logic [2:0]  idx;
   logic [10:0] fcmd;
   logic [3:0]  words;
   int failures = 0;
   int n_tests = 0;
   int c;
   // ==========================================
   // clock, design and memory model
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   host_bus_strobes_and_straps DUT
   (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .cfg_mem_present_strap_i(strap),
      .cfg_mem_serial_in_i(strap ? mem_do : lvl),
      .cfg_mem_serial_out_o(so), .cfg_mem_serial_clock_o(sk),
      .cfg_mem_select_o(sel), .wide_bus_variant_i(wide), .addr_i(addr),
      .address_qualifier_n_i(aq_n), .address_latch_strobe_n_i(als_n),
      .latch_mode_i(lmode), .sync_write_read_select_i(sync_write_read_select),
      .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .write_data_i(wd),
      .cfg_read_idx_i(idx), .chip_power_down_n_i(pd_n),
      .local_select_n_o(ls_n), .bus_16bit_o(b16), .cfg_mem_present_o(pres),
      .sync_is_write_o(sw), .async_write_o(aw), .async_write_data_o(awd),
      .async_read_o(ar), .read_data_o(rdd), .latched_addr_o(laddr),
      .load_done_o(done), .power_down_o(pdo)
   );
   cfg_mem_model u_mem
   (
      .sk_i(sk), .cs_i(sel), .di_i(so), .do_o(mem_do),
      .first_cmd_o(fcmd), .words_o(words)
   );
   // ==========================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : cyc
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic do_reset(input logic s, input logic l);
      strap = s;
      lvl = l;
      rst_n_i = 1'b0;
      cyc(2);
      rst_n_i = 1'b1;
      cyc(3);
   endtask : do_reset
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // ==========================================
   // scenarios
   task automatic t_straps;
      do_reset(1'b0, 1'b0);
      chk(b16, 1'b0);
      wide = 1'b1;
      do_reset(1'b0, 1'b1);
      chk(b16, 1'b0);
      wide = 1'b0;
      do_reset(1'b0, 1'b1);
      chk(b16, 1'b1);
      chk(pres, 1'b0);
      lvl = 1'b0;
      cyc(500);
      chk(b16, 1'b1);
      chk(sel, 1'b0);
      chk(done, 1'b1);
   endtask : t_straps
   task automatic t_sync_power;
      aq_n = 1'b0;
      sync_write_read_select = 1'b1;
      cyc(1);
      chk(sw, 1'b1);
      sync_write_read_select = 1'b0;
      pd_n = 1'b0;
      cyc(1);
      chk(sw, 1'b0);
      chk(pdo, 1'b1);
      pd_n = 1'b1;
      cyc(1);
      chk(pdo, 1'b0);
   endtask : t_sync_power
   task automatic t_async;
      wd = 16'hbeef;
      wr_n = 1'b0;
      cyc(1);
      chk({aw, awd}, {1'b1, 16'hbeef});
      aq_n = 1'b1;
      wd = 16'h1234;
      cyc(1);
      chk(aw, 1'b0);
      chk(awd, 16'hbeef);
      wr_n = 1'b1;
      rd_n = 1'b0;
      cyc(1);
      chk(ar, 1'b0);
      aq_n = 1'b0;
      cyc(1);
      chk(ar, 1'b1);
      rd_n = 1'b1;
   endtask : t_async
   task automatic t_decode;
      addr = {12'h030, 3'h5};
      cyc(1);
      chk(ls_n, 1'b0);
      addr = {12'h031, 3'h0};
      cyc(1);
      chk(ls_n, 1'b1);
      lmode = 1'b1;
      addr = {12'h030, 3'h2};
      als_n = 1'b0;
      cyc(1);
      als_n = 1'b1;
      cyc(1);
      addr = 15'h7fff;
      aq_n = 1'b1;
      cyc(2);
      chk(laddr, {12'h030, 3'h2});
      chk(ls_n, 1'b0);
      lmode = 1'b0;
      cyc(1);
      chk(ls_n, 1'b1);
   endtask : t_decode
   task automatic t_load;
      do_reset(1'b1, 1'b0);
      chk(pres, 1'b1);
      for (c = 0; c < 500 && sk !== 1'b1; c++) cyc(1);
      for (c = 0; c < 1000 && sk !== 1'b0; c++) cyc(1);
      for (c = 0; c < 1000 && sk !== 1'b1; c++) cyc(1);
      for (c = 0; c < 1000 && sk !== 1'b0; c++) cyc(1);
      chk(c, 200);
      for (c = 0; c < 12000 && words == 4'h0; c++) cyc(1);
      chk(fcmd, 11'b110_00000_000);
      cyc(2);
      idx = 3'h0;
      aq_n = 1'b0;
      rd_n = 1'b0;
      cyc(3);
      chk(rdd, 16'h1230);
      rd_n = 1'b1;
      aq_n = 1'b1;
      cyc(2);
      chk(rdd, 16'h0000);
      chk(done, 1'b0);
      for (c = 0; c < 12000 && words < 4'h2; c++) cyc(1);
      idx = 3'h1;
      aq_n = 1'b0;
      rd_n = 1'b0;
      cyc(3);
      chk(rdd, 16'h1231);
      rd_n = 1'b1;
      aq_n = 1'b1;
   endtask : t_load
   // ==========================================
   // main sequence and watchdog
   initial
   begin
      {rst_n_i, strap, lvl, wide, sync_write_read_select, lmode, idx} = '0;
      {aq_n, als_n, wr_n, rd_n, pd_n} = 5'h1f;
      addr = 15'h0000;
      wd = 16'h0000;
      t_straps;
      t_sync_power;
      t_async;
      t_decode;
      t_load;
      end_of_test;
   end
   initial
   begin
      repeat (30000) @(posedge clk_sys_i);
      failures++;
      end_of_test;
   end
endmodule : host_bus_strobes_and_straps_tb
